/* ubr_pkg.sv */
// What this block does
// - One receive and one transmit data line; RTS and CTS active low.
// - Flow control selects RTS/CTS handshaking or none.
// - Line rate programmable from about 1221 baud to 3.0 Mbaud.
// - Eight data bits, parity none/odd/even, one or two stop bits.
// - Baud rate equals divisor setting divided by 0.004096.
// - Divisors 39, 472 and 3775 give 9600, 115200 and 921600 baud.
// - Receive line held low past break timeout requests a full reset.
// - Device can hold its transmit line low as a wake-up break.
// - All serial outputs are high impedance while reset is held.
// - After reset the host bus connects to the device's own port.
// - Bypass command enters deep sleep one cycle later and routes host bus to spare pins 7..4 two cycles later.
// - Bypass is left only through reset.
//
// Purpose: Shared constants and types of the serial port with bypass.
// Assumes: Clock of 10 MHz.
// Notes:   Divisor scale keeps the baud generator exact at this clock.
package ubr_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned BRK_UNIT_NS   = 1_000_000;
  localparam int unsigned BRK_UNIT_CYC  = BRK_UNIT_NS / CLK_PERIOD_NS;
  // Modulus of the baud accumulator: clock rate times 0.004096 seconds.
  localparam logic [15:0] NCO_MOD       = 16'((CLK_HZ / 1000) * 4096 / 1000);

  // ********************************************************************
  // Divisor settings
  // ********************************************************************
  // common divisors
  localparam logic [15:0] DIV_9600      = 16'h0027;
  localparam logic [15:0] DIV_115200    = 16'h01d8;
  localparam logic [15:0] DIV_921600    = 16'h0ebf;
  localparam logic [15:0] DIV_MIN       = 16'h0005;
  localparam logic [15:0] DIV_MAX       = 16'h3000;
  localparam logic [15:0] DIV_RESET     = DIV_115200;
  localparam int unsigned DATA_BITS     = 8;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ODD  = 2'b01,
    PAR_EVEN = 2'b10
  } ubr_parity_t;

  typedef enum logic [2:0] {
    FR_IDLE  = 3'b000,
    FR_START = 3'b001,
    FR_DATA  = 3'b010,
    FR_PAR   = 3'b011,
    FR_STOP  = 3'b100
  } ubr_frame_t;

endpackage

/* ubr_rx_if.sv */
// Purpose: Carries settings and received characters between top and receiver.
// Assumes: One clock domain.
// Notes:   The line level is already synchronised.
`timescale 1ns/1ps
interface ubr_rx_if;
  import ubr_pkg::*;
  logic [15:0] divisor;
  ubr_parity_t parity;
  logic        rxd;
  logic [7:0]  data;
  logic        valid;
  logic        par_err;
  logic        frm_err;
  modport top (output divisor, parity, rxd,
               input  data, valid, par_err, frm_err);
  modport rx  (input  divisor, parity, rxd,
               output data, valid, par_err, frm_err);
endinterface

/* ubr_rx.sv */
// Purpose: Receiver; samples each bit at its middle.
// Assumes: Divisor already clamped to the supported range.
// Notes:   Only the first stop bit is checked.
`timescale 1ns/1ps
module ubr_rx (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  ubr_rx_if.rx      rif
);
  import ubr_pkg::*;

  typedef struct packed {
    ubr_frame_t  st;
    logic [15:0] acc;
    logic [2:0]  bitn;
    logic [7:0]  shreg;
    logic [7:0]  data;
    logic        valid;
    logic        par_err;
    logic        frm_err;
  } ubr_rx_st_t;

  ubr_rx_st_t s;
  ubr_rx_st_t n;
  logic [15:0] sum;
  logic        tick;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    n = s;
    n.valid = 1'b0;
    sum = s.acc + rif.divisor;
    tick = (sum >= NCO_MOD);
    n.acc = tick ? sum - NCO_MOD : sum;
    unique case (s.st)
      FR_IDLE: begin
        if (!rif.rxd) begin
          n.st = FR_START;
          n.acc = NCO_MOD >> 1;
        end
      end
      FR_START: begin
        if (tick) begin
          n.st = rif.rxd ? FR_IDLE : FR_DATA;
          n.bitn = 3'h0;
        end
      end
      FR_DATA: begin
        if (tick) begin
          n.shreg = {rif.rxd, s.shreg[7:1]};
          n.bitn = s.bitn + 3'h1;
          if (s.bitn == 3'(DATA_BITS - 1)) begin
            n.st = (rif.parity == PAR_NONE) ? FR_STOP : FR_PAR;
          end
        end
      end
      FR_PAR: begin
        if (tick) begin
          n.st = FR_STOP;
          n.par_err = (^s.shreg) ^ rif.rxd ^ (rif.parity == PAR_ODD);
        end
      end
      FR_STOP: begin
        if (tick) begin
          n.st = FR_IDLE;
          n.frm_err = ~rif.rxd;
          n.data = s.shreg;
          n.valid = 1'b1;
          if (rif.parity == PAR_NONE) begin
            n.par_err = 1'b0;
          end
        end
      end
      default: n.st = FR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '{st: FR_IDLE, default: '0};
    end else begin
      s <= n;
    end
  end

  assign rif.data    = s.data;
  assign rif.valid   = s.valid;
  assign rif.par_err = s.par_err;
  assign rif.frm_err = s.frm_err;

  // ********************************************************************
  // Checks
  // ********************************************************************
  AST_RX_NO_PAR_ERR: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s.valid && rif.parity == PAR_NONE |-> !s.par_err)
    else $error("parity error flagged with parity off");

  AST_RX_START_GLITCH: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s.st == FR_START && tick && rif.rxd |=> s.st == FR_IDLE)
    else $error("high start sample did not abort the frame");

endmodule

/* ubr_top.sv */
// Purpose: Serial port with break reset request, break send and bypass.
// Assumes: Pin inputs are asynchronous; pin drivers resolve the enables.
// Notes:   break_reset_o must be fed back as a full reset of the device.
`timescale 1ns/1ps
module ubr_top #(
  parameter int unsigned BRK_UNIT_CYCLES = ubr_pkg::BRK_UNIT_CYC
) (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire logic                 rxd_i,
  output logic                      txd_o,
  output logic                      txd_oe_o,
  input  wire logic                 cts_n_i,
  output logic                      rts_n_o,
  output logic                      rts_n_oe_o,
  input  wire logic [3:0]           pio_i,
  output logic      [3:0]           pio_o,
  output logic      [3:0]           pio_oe_o,
  input  wire logic [15:0]          baud_divisor_setting_i,
  input  wire ubr_pkg::ubr_parity_t parity_i,
  input  wire logic                 two_stop_i,
  input  wire logic                 flow_ctrl_en_i,
  input  wire logic [15:0]          break_reset_timeout_setting_i,
  input  wire logic                 send_break_i,
  input  wire logic                 bypass_control_command_i,
  input  wire logic [7:0]           tx_data_i,
  input  wire logic                 tx_valid_i,
  output logic                      tx_ready_o,
  input  wire logic                 rx_room_i,
  output logic      [7:0]           rx_data_o,
  output logic                      rx_valid_o,
  output logic                      rx_par_err_o,
  output logic                      rx_frm_err_o,
  output logic                      break_reset_o,
  output logic                      deep_sleep_o
);
  import ubr_pkg::*;

  typedef struct packed {
    ubr_frame_t  st;
    logic [15:0] acc;
    logic [2:0]  bitn;
    logic [7:0]  shreg;
    logic        par;
    logic        has_par;
    logic        stop2;
    logic        txd;
    logic        txd_oe;
    logic        rts_n;
    logic        rts_oe;
    logic [3:0]  pio;
    logic [3:0]  pio_oe;
    logic        bypass;
    logic [15:0] unit_cyc;
    logic [15:0] brk_units;
    logic        brk_fired;
    logic        brk_rst;
  } ubr_top_st_t;

  ubr_top_st_t s;
  ubr_top_st_t n;
  logic [3:0]  pin_in;
  logic [3:0]  sync_a;
  logic [3:0]  sync_b;
  logic        rxd_s;
  logic        cts_n_s;
  logic [15:0] div_eff;
  logic [15:0] sum;
  logic        tick;
  logic        tx_fire;

  ubr_rx_if rif ();

  // ********************************************************************
  // Pin synchronisers: receive, clear-to-send, pins 5 and 7
  // ********************************************************************
  assign pin_in = {pio_i[3], pio_i[1], cts_n_i, rxd_i};

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        sync_a[i] <= 1'b1;
        sync_b[i] <= 1'b1;
      end else begin
        sync_a[i] <= pin_in[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  assign rxd_s   = sync_b[0];
  assign cts_n_s = sync_b[1];

  // ********************************************************************
  // Rate and receiver
  // ********************************************************************
  // clamp to range
  always_comb begin
    if (baud_divisor_setting_i < DIV_MIN) begin
      div_eff = DIV_MIN;
    end else if (baud_divisor_setting_i > DIV_MAX) begin
      div_eff = DIV_MAX;
    end else begin
      div_eff = baud_divisor_setting_i;
    end
  end

  assign rif.divisor = div_eff;
  assign rif.parity  = parity_i;
  assign rif.rxd     = s.bypass | rxd_s;

  ubr_rx u_rx (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .rif      (rif)
  );

  assign tx_ready_o = (s.st == FR_IDLE) && !s.bypass && !send_break_i &&
                      (!flow_ctrl_en_i || !cts_n_s);
  assign tx_fire = tx_valid_i && tx_ready_o;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    n = s;
    n.brk_rst = 1'b0;
    n.txd_oe = 1'b1;
    n.rts_oe = 1'b1;
    n.rts_n = flow_ctrl_en_i ? !rx_room_i : 1'b0;
    sum = s.acc + div_eff;
    tick = (sum >= NCO_MOD);
    n.acc = tick ? sum - NCO_MOD : sum;

    if (s.bypass) begin
      n.st = FR_IDLE;
      n.txd = sync_b[2];
      n.rts_n = sync_b[3];
      n.pio = {1'b0, cts_n_s, 1'b0, rxd_s};
      n.pio_oe = 4'b0101;
    end else begin
      unique case (s.st)
        FR_IDLE: begin
          n.txd = !send_break_i;
          if (tx_fire) begin
            n.st = FR_START;
            n.txd = 1'b0;
            n.acc = 16'h0000;
            n.bitn = 3'h0;
            n.shreg = tx_data_i;
            n.par = (^tx_data_i) ^ (parity_i == PAR_ODD);
            n.has_par = (parity_i != PAR_NONE);
            n.stop2 = two_stop_i;
          end
        end
        FR_START: begin
          if (tick) begin
            n.st = FR_DATA;
            n.txd = s.shreg[0];
          end
        end
        FR_DATA: begin
          if (tick) begin
            n.shreg = s.shreg >> 1;
            n.bitn = s.bitn + 3'h1;
            n.txd = s.shreg[1];
            if (s.bitn == 3'(DATA_BITS - 1)) begin
              n.st = s.has_par ? FR_PAR : FR_STOP;
              n.txd = s.has_par ? s.par : 1'b1;
            end
          end
        end
        FR_PAR: begin
          if (tick) begin
            n.st = FR_STOP;
            n.txd = 1'b1;
          end
        end
        FR_STOP: begin
          if (tick) begin
            if (s.stop2) begin
              n.stop2 = 1'b0;
            end else begin
              n.st = FR_IDLE;
            end
          end
        end
        default: n.st = FR_IDLE;
      endcase
      if (bypass_control_command_i) begin
        n.bypass = 1'b1;
      end
    end

    if (rxd_s) begin
      n.unit_cyc = 16'h0000;
      n.brk_units = 16'h0000;
      n.brk_fired = 1'b0;
    end else begin
      n.unit_cyc = s.unit_cyc + 16'h0001;
      if (s.unit_cyc == 16'(BRK_UNIT_CYCLES - 1)) begin
        n.unit_cyc = 16'h0000;
        if (s.brk_units != 16'hffff) begin
          n.brk_units = s.brk_units + 16'h0001;
        end
      end
      if (s.brk_units > break_reset_timeout_setting_i && !s.brk_fired) begin
        n.brk_rst = 1'b1;
        n.brk_fired = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s <= '{st: FR_IDLE, txd: 1'b1, rts_n: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  assign txd_o         = s.txd;
  assign txd_oe_o      = s.txd_oe;
  assign rts_n_o       = s.rts_n;
  assign rts_n_oe_o    = s.rts_oe;
  assign pio_o         = s.pio;
  assign pio_oe_o      = s.pio_oe;
  assign break_reset_o = s.brk_rst;
  assign deep_sleep_o  = s.bypass;
  assign rx_data_o     = rif.data;
  assign rx_valid_o    = rif.valid;
  assign rx_par_err_o  = rif.par_err;
  assign rx_frm_err_o  = rif.frm_err;

  // ********************************************************************
  // Checks
  // ********************************************************************
  AST_TX_START_LOW: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    tx_fire |=> !txd_o && s.st == FR_START)
    else $error("accepted character did not begin with a low start bit");

  AST_CTS_BLOCKS: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    flow_ctrl_en_i && cts_n_s |-> !tx_ready_o)
    else $error("transmit accepted while clear-to-send negated");

  AST_OE_AFTER_RESET: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !txd_oe_o |-> ##2 txd_oe_o && rts_n_oe_o)
    else $error("serial outputs not driven after reset release");

  AST_BYPASS_STICKY: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    deep_sleep_o |=> deep_sleep_o && !tx_ready_o)
    else $error("bypass left without reset");

  AST_BYPASS_ROUTE: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    deep_sleep_o && $past(deep_sleep_o) |=>
      txd_o == $past(sync_b[2], 1) && pio_o[0] == $past(rxd_s, 1))
    else $error("bypass routing wrong");

  AST_BREAK_SEND: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s.st == FR_IDLE && !s.bypass && send_break_i |=> !txd_o)
    else $error("break not sent on transmit line");

  AST_BREAK_RESET_PULSE: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    break_reset_o |-> $past(!rxd_s) ##1 !break_reset_o)
    else $error("break reset not a single pulse on a low line");

  AST_STOP_HIGH: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    s.st == FR_STOP && !s.bypass |-> txd_o)
    else $error("stop bit not high");

endmodule

/* ubr_host_model.sv */
// Purpose: Host serial port facing the block's receive and transmit pins.
// Assumes: Fast test rate, a bit of 11 clocks sent and 1085 ns sampled.
// Notes:   The host keeps its transmit line idle high between frames.
`timescale 1ns/1ps
module ubr_host_model (
  input  wire logic clk_i,
  input  wire logic txd_i,
  output logic      rxd_o,
  output logic      cts_n_o
);
  initial begin
    rxd_o   = 1'b1;
    cts_n_o = 1'b1;
  end

  task automatic lines(input logic r, input logic c);
    @(posedge clk_i);
    rxd_o   <= r;
    cts_n_o <= c;
  endtask

  task automatic send(input logic [7:0] d, input logic [1:0] par,
                      input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    int          n;
    n = (par == 2'b00) ? 10 : 11;
    f = {~bad_stop, (par[0] ? ~^d : ^d) ^ bad_par, d, 1'b0};
    if (par == 2'b00) f[9] = ~bad_stop;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (10) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask

  task automatic recv(input logic par_on, output logic [11:0] f);
    int n;
    n = par_on ? 12 : 11;
    f = '1;
    @(negedge txd_i);
    #542;
    for (int i = 0; i < n; i++) begin
      f[i] = txd_i;
      #1085;
    end
  endtask
endmodule

/* ubr_top_tb_top.sv */
// Purpose: Self-checking bench of the serial port with break and bypass.
// Assumes: Break unit shortened to 8 clocks; fast rate of divisor 3775.
// Notes:   Transmit pin has a pull-up, so a released line reads high.
`timescale 1ns/1ps
module ubr_top_tb_top;
  import ubr_pkg::*;
  localparam int UNIT = 8;
  logic        clk_i;
  logic        arst_n;
  logic        rxd;
  logic        cts_n;
  wire         txd_w;
  logic        txd, txd_oe, rts_n, rts_oe, two_stop, flow, send_brk;
  logic        byp_cmd, tx_valid, room, tx_ready, rx_valid, par_err;
  logic        frm_err, brk_rst, sleep;
  logic [3:0]  pio_i, pio_o, pio_oe;
  logic [15:0] div, brk_to;
  logic [7:0]  tx_data, rx_data;
  logic [11:0] fr;
  ubr_parity_t par;
  int          errors, n_tests, cnt;
  logic [15:0] dv [4] = '{DIV_9600, DIV_115200, DIV_MIN, DIV_MAX};
  ubr_parity_t pm [4] = '{PAR_NONE, PAR_EVEN, PAR_ODD, PAR_EVEN};

  // ****************************************************************
  // Harness
  // ****************************************************************
  assign txd_w = txd_oe ? txd : 1'b1;
  ubr_top #(.BRK_UNIT_CYCLES(UNIT)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n), .rxd_i(rxd), .txd_o(txd),
    .txd_oe_o(txd_oe), .cts_n_i(cts_n), .rts_n_o(rts_n),
    .rts_n_oe_o(rts_oe), .pio_i(pio_i), .pio_o(pio_o), .pio_oe_o(pio_oe),
    .baud_divisor_setting_i(div), .parity_i(par), .two_stop_i(two_stop),
    .flow_ctrl_en_i(flow), .break_reset_timeout_setting_i(brk_to),
    .send_break_i(send_brk), .bypass_control_command_i(byp_cmd),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_room_i(room), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_par_err_o(par_err), .rx_frm_err_o(frm_err),
    .break_reset_o(brk_rst), .deep_sleep_o(sleep));
  ubr_host_model host (.clk_i(clk_i), .txd_i(txd_w), .rxd_o(rxd),
                       .cts_n_o(cts_n));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #5_000_000;
    errors++;
    results;
  end

  task automatic chk(input string nm, input int e, input logic [15:0] g,
                     input int tol = 0);
    n_tests++;
    if ($isunknown(g) || int'(g) > e + tol || int'(g) + tol < e) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    arst_n <= 1'b0;
    cyc(16);
    @(negedge clk_i);
    chk("enables in reset", 0, {txd_oe, rts_oe, pio_oe});
    @(posedge clk_i);
    arst_n <= 1'b1;
    cyc(3);
  endtask

  task automatic tx_go(input logic [7:0] d);
    int n;
    @(posedge clk_i);
    tx_data  <= d;
    tx_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (tx_ready !== 1'b1 && n < 3000);
    @(posedge clk_i);
    tx_valid <= 1'b0;
  endtask

  task automatic wait_cnt(input bit on_rdy, output int n);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((on_rdy ? tx_ready !== 1'b1 : txd === 1'b0) && n < 20000);
  endtask

  task automatic rx_wait;
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (rx_valid !== 1'b1 && n < 400);
    chk("rx valid", 1, rx_valid);
    @(negedge clk_i);
    chk("rx valid pulse", 0, rx_valid);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    logic [7:0] d;
    int         b;
    arst_n = 1'b0;
    {two_stop, flow, send_brk, byp_cmd, tx_valid, room} = '0;
    pio_i = '0;
    div = DIV_921600;
    brk_to = 16'h000f;
    par = PAR_NONE;
    tx_data = '0;
    do_reset;
    chk("enables after reset", 3, {txd_oe, rts_oe});
    chk("bypass after reset", 0, {pio_oe, sleep});
    chk("idle txd", 1, txd);
    $display("test reset done");
    @(posedge clk_i);
    flow <= 1'b1;
    cyc(4);
    @(negedge clk_i);
    chk("ready cts negated", 0, tx_ready);
    chk("rts without room", 1, rts_n);
    host.lines(1'b1, 1'b0);
    room <= 1'b1;
    cyc(4);
    @(negedge clk_i);
    chk("ready cts asserted", 1, tx_ready);
    chk("rts with room", 0, rts_n);
    host.lines(1'b1, 1'b1);
    flow <= 1'b0;
    cyc(4);
    @(negedge clk_i);
    chk("ready no flow", 1, tx_ready);
    chk("rts no flow", 0, rts_n);
    $display("test flow control done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_i);
      par      <= ubr_parity_t'(i % 3);
      two_stop <= i[0];
      d = 8'h35 + 8'(i * 29);
      fork
        begin
          tx_go(d);
          wait_cnt(1'b1, cnt);
        end
        host.recv(i % 3 != 0, fr);
      join
      chk("tx start", 0, fr[0]);
      chk("tx data", d, fr[8:1]);
      if (i % 3 != 0)
        chk("tx parity", (i % 3 == 1) ? ~^d : ^d, fr[9]);
      b = 10 + int'(i % 3 != 0) + int'(i[0]);
      b = b * int'(NCO_MOD) / int'(DIV_921600);
      chk("tx frame clocks", b, cnt, 3);
    end
    $display("test transmit frames done");
    foreach (dv[k]) begin
      @(posedge clk_i);
      div <= dv[k];
      tx_go(8'hff);
      wait_cnt(1'b0, cnt);
      b = int'(NCO_MOD) / int'(dv[k]);
      chk("start bit clocks", b, cnt - 1, 2);
      do_reset;
    end
    @(posedge clk_i);
    div <= DIV_921600;
    $display("test baud divisors done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      par <= pm[i];
      d = 8'hc5 ^ 8'(i * 19);
      fork
        host.send(d, pm[i], i == 2, i == 3);
        rx_wait;
      join
      chk("rx data", d, rx_data);
      chk("rx parity error", int'(i == 2), par_err);
      chk("rx stop error", int'(i == 3), frm_err);
    end
    $display("test receive frames done");
    @(posedge clk_i);
    send_brk <= 1'b1;
    cyc(40);
    @(negedge clk_i);
    chk("break on txd", 0, txd);
    chk("ready in break", 0, tx_ready);
    @(posedge clk_i);
    send_brk <= 1'b0;
    cyc(4);
    @(negedge clk_i);
    chk("txd after break", 1, txd);
    $display("test break send done");
    host.lines(1'b0, 1'b1);
    wait_cnt(1'b0, cnt);
    cnt = 0;
    do begin
      @(negedge clk_i);
      cnt++;
    end while (brk_rst !== 1'b1 && cnt < 200);
    chk("break reset clocks", (int'(brk_to) + 1) * UNIT + 3, cnt, 3);
    cnt = 0;
    repeat (60) begin
      @(negedge clk_i);
      if (brk_rst === 1'b1) cnt++;
    end
    chk("single break reset", 0, cnt);
    host.lines(1'b1, 1'b1);
    $display("test break reset done");
    @(posedge clk_i);
    byp_cmd <= 1'b1; // links closed
    @(posedge clk_i);
    byp_cmd <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk("deep sleep", 1, sleep);
    chk("pin enables", 5, pio_oe);
    chk("ready in bypass", 0, tx_ready);
    host.lines(1'b0, 1'b0);
    pio_i <= 4'b1010;
    cyc(6);
    @(negedge clk_i);
    chk("bypass txd rts", 3, {txd, rts_n});
    chk("bypass host lines", 0, {pio_o[2], pio_o[0]});
    host.lines(1'b1, 1'b1);
    pio_i <= 4'b0000;
    cyc(6);
    @(negedge clk_i);
    chk("bypass txd rts low", 0, {txd, rts_n});
    chk("bypass host idle", 3, {pio_o[2], pio_o[0]});
    do_reset;
    chk("bypass left", 0, {pio_oe, sleep});
    chk("port restored", 3, {txd_oe, rts_oe});
    $display("test bypass done");
    results;
  end
endmodule
